// ===== verilog/pll_clock_generator.sv
// clock generator: divider chain, phase and lock detection, oscillator configuration registers
//
// Overview of operation
// - oscillator config two written only while unprotected and bus runs from the synthesizer
// - bit 1 enables oscillator monitor reset; writes ignored while external oscillator enabled
// - bit 0 selects oscillator swing; frozen while external oscillator enabled
// - reference is internal RC tick, or crystal divided by divider plus one
// - controlled oscillator runs at twice reference times multiplier plus one
// - when locked, output clock is oscillator clock divided by divider plus one
// - when unlocked, output clock is oscillator clock divided by four
// - with synthesizer selected, bus clock is half the output clock
// - phase detector emits correction pulses between feedback and reference edges
// - lock decided by comparing feedback and reference frequencies; dead reference prevents lock
// - lock status is read-only, set inside lock tolerance, cleared outside unlock tolerance
// - with enable set, every lock status toggle raises an interrupt request
// - reference loss drops lock; oscillator then runs slow per its range setting
// - with watchdog RC clock selected and watchdog stopped in stop mode, watchdog resumes after stop only after an extra synchronisation delay
// - writing 0x26 to protect register unprotects; any other write protects
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module pll_clock_generator
	import pll_clock_pkg::*;
#(
	parameter int REF_TIMEOUT = REF_TIMEOUT_CYCLES
)
(
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic IRC_TICK,
	input wire logic OSC_TICK,
	input wire logic VCO_TICK,
	input wire logic STOP_MODE,
	output logic REF_TICK,
	output logic FB_TICK,
	output logic PUMP_UP,
	output logic PUMP_DOWN,
	output logic PLL_TICK,
	output logic BUS_TICK,
	output logic BUS_FROM_PLL,
	output logic EXT_OSC_ENABLE,
	output logic OSC_MONITOR_RESET_EN,
	output logic OSC_FULL_SWING,
	output logic [1:0] REF_RANGE,
	output logic [1:0] VCO_RANGE,
	output logic LOCK,
	output logic LOCK_IRQ,
	output logic REF_LOST,
	output logic WATCHDOG_RUN
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] synth;
		logic [7:0] reference_divider;
		logic [7:0] output_divider;
		logic [7:0] irq_enable;
		logic [7:0] clock_select;
		logic [7:0] osc_one;
		logic [7:0] osc_two;
		logic protect;
		logic lock_flag;
		logic [7:0] rdata;
		logic [3:0] ref_cnt;
		logic ref_tick;
		logic [5:0] fb_cnt;
		logic fb_tick;
		logic fb_half;
		logic [4:0] post_cnt;
		logic pll_tick;
		logic bus_half;
		logic bus_tick;
		logic pump_up;
		logic pump_down;
		logic [2:0] win_cnt;
		logic [7:0] fb_count;
		logic raw_lock;
		logic [15:0] ref_idle;
		logic ref_lost;
		logic lock_meta;
		logic lock_sync;
		logic lock;
		logic stop_prev;
		logic [1:0] wdog_cnt;
		logic wdog_run;
	} state_s;

	localparam logic [7:0] FB_EXPECT = 8'(2 * LOCK_WINDOW);
	localparam logic [7:0] LOCK_TOL_W = 8'(LOCK_TOL);
	localparam logic [7:0] UNLOCK_TOL_W = 8'(UNLOCK_TOL);
	localparam logic [2:0] WIN_LAST = 3'(LOCK_WINDOW - 1);
	localparam logic [15:0] REF_TIMEOUT_W = 16'(REF_TIMEOUT);

	state_s st;
	state_s next_st;
	logic [1:0] rst_pipe;
	logic rst_n_sync;

	// ****************************************
	// reset release
	// ****************************************
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n_sync = rst_pipe[1];

	// ****************************************
	// next state
	// ****************************************
	logic external_osc_enable;
	logic bus_pll;
	logic wr_ok;
	logic ref_event;
	logic fb_event;
	logic [7:0] fb_diff;
	logic [4:0] post_limit;

	always_comb
	begin
		next_st = st;
		external_osc_enable = st.osc_one[OSC1_ENABLE_BIT];
		bus_pll = st.clock_select[CLKS_BUS_PLL_BIT];
		wr_ok = WR && !st.protect;
		fb_diff = 8'h00;

		// register writes
		if (WR && ADDR == ADDR_PROTECT)
			next_st.protect = (WDATA != PROTECT_UNLOCK_KEY);
		if (wr_ok && ADDR == ADDR_SYNTH)
			next_st.synth = WDATA;
		if (wr_ok && ADDR == ADDR_REFERENCE_DIVIDER)
			next_st.reference_divider = WDATA & 8'hCF;
		if (wr_ok && ADDR == ADDR_OUTPUT_DIVIDER)
			next_st.output_divider = WDATA & 8'h1F;
		if (WR && ADDR == ADDR_IRQ_ENABLE)
			next_st.irq_enable = WDATA & 8'h10;
		if (wr_ok && ADDR == ADDR_CLOCK_SELECT)
			next_st.clock_select = WDATA & 8'h86;
		if (wr_ok && ADDR == ADDR_OSC_ONE)
			next_st.osc_one = WDATA & 8'h80;
		// both fields freeze while the crystal runs, so the whole write is dropped
		if (wr_ok && bus_pll && ADDR == ADDR_OSC_TWO && !external_osc_enable)
		begin
			next_st.osc_two[OSC2_MONITOR_BIT] = WDATA[OSC2_MONITOR_BIT];
			next_st.osc_two[OSC2_SWING_BIT] = WDATA[OSC2_SWING_BIT];
		end

		// read data, one cycle after the strobe
		next_st.rdata = 8'h00;
		if (RD)
		begin
			unique case (ADDR)
				ADDR_SYNTH: next_st.rdata = st.synth;
				ADDR_REFERENCE_DIVIDER: next_st.rdata = st.reference_divider;
				ADDR_OUTPUT_DIVIDER: next_st.rdata = st.output_divider;
				ADDR_IRQ_ENABLE: next_st.rdata = st.irq_enable;
				ADDR_IRQ_FLAG:
				begin
					next_st.rdata[IRQ_LOCK_BIT] = st.lock_flag;
					next_st.rdata[STATUS_LOCK_BIT] = st.lock;
				end
				ADDR_CLOCK_SELECT: next_st.rdata = st.clock_select;
				ADDR_OSC_ONE: next_st.rdata = st.osc_one;
				ADDR_PROTECT: next_st.rdata = {7'h00, st.protect};
				ADDR_OSC_TWO: next_st.rdata = st.osc_two;
				default: next_st.rdata = 8'h00;
			endcase
		end

		// reference divider
		next_st.ref_tick = 1'b0;
		if (!external_osc_enable)
		begin
			next_st.ref_cnt = 4'h0;
			next_st.ref_tick = IRC_TICK;
		end
		else if (OSC_TICK)
		begin
			if (st.ref_cnt >= st.reference_divider[3:0])
			begin
				next_st.ref_cnt = 4'h0;
				next_st.ref_tick = 1'b1;
			end
			else
				next_st.ref_cnt = st.ref_cnt + 4'h1;
		end

		// feedback divider; the loop's extra factor two sits in the phase comparison
		next_st.fb_tick = 1'b0;
		if (VCO_TICK)
		begin
			if (st.fb_cnt >= st.synth[5:0])
			begin
				next_st.fb_cnt = 6'h00;
				next_st.fb_tick = 1'b1;
			end
			else
				next_st.fb_cnt = st.fb_cnt + 6'h01;
		end
		if (st.fb_tick)
			next_st.fb_half = !st.fb_half;

		// phase detector: a pump stays on from one edge until the other arrives
		ref_event = st.ref_tick;
		fb_event = st.fb_tick && st.fb_half;
		next_st.pump_up = st.pump_up || ref_event;
		next_st.pump_down = st.pump_down || fb_event;
		if (next_st.pump_up && next_st.pump_down)
		begin
			next_st.pump_up = 1'b0;
			next_st.pump_down = 1'b0;
		end

		// lock detector: feedback edges counted over a window of reference edges
		if (st.fb_tick && st.fb_count != 8'hFF)
			next_st.fb_count = st.fb_count + 8'h01;
		if (st.ref_tick)
		begin
			next_st.ref_idle = 16'h0000;
			next_st.ref_lost = 1'b0;
			next_st.win_cnt = st.win_cnt + 3'h1;
			if (st.win_cnt == WIN_LAST)
			begin
				next_st.win_cnt = 3'h0;
				next_st.fb_count = 8'h00;
				fb_diff = (st.fb_count > FB_EXPECT) ? st.fb_count - FB_EXPECT : FB_EXPECT - st.fb_count;
				if (fb_diff <= LOCK_TOL_W)
					next_st.raw_lock = 1'b1;
				else if (fb_diff > UNLOCK_TOL_W)
					next_st.raw_lock = 1'b0;
			end
		end
		else if (st.ref_idle >= REF_TIMEOUT_W)
		begin
			// a dead reference never closes a window, so it must force unlock here
			next_st.ref_lost = 1'b1;
			next_st.raw_lock = 1'b0;
			next_st.win_cnt = 3'h0;
			next_st.fb_count = 8'h00;
		end
		else
			next_st.ref_idle = st.ref_idle + 16'h0001;

		// lock result resynchronised before it becomes visible
		next_st.lock_meta = st.raw_lock;
		next_st.lock_sync = st.lock_meta;
		next_st.lock = st.lock_sync;
		if (WR && ADDR == ADDR_IRQ_FLAG && WDATA[IRQ_LOCK_BIT])
			next_st.lock_flag = 1'b0;
		if (st.lock_sync != st.lock)
			next_st.lock_flag = 1'b1;

		// post divider
		post_limit = st.lock ? st.output_divider[4:0] : UNLOCKED_POST_DIV;
		next_st.pll_tick = 1'b0;
		if (VCO_TICK)
		begin
			if (st.post_cnt >= post_limit)
			begin
				next_st.post_cnt = 5'h00;
				next_st.pll_tick = 1'b1;
			end
			else
				next_st.post_cnt = st.post_cnt + 5'h01;
		end

		// bus clock
		next_st.bus_tick = 1'b0;
		if (bus_pll)
		begin
			if (st.pll_tick)
			begin
				next_st.bus_half = !st.bus_half;
				next_st.bus_tick = st.bus_half;
			end
		end
		else
		begin
			next_st.bus_half = 1'b0;
			next_st.bus_tick = OSC_TICK;
		end

		// watchdog restart after stop
		next_st.stop_prev = STOP_MODE;
		if (st.stop_prev && !STOP_MODE && st.clock_select[CLKS_WDOG_RC_BIT] && st.clock_select[CLKS_WDOG_STOP_DIS_BIT])
			next_st.wdog_cnt = WDOG_SYNC_CYCLES;
		else if (st.wdog_cnt != 2'h0)
			next_st.wdog_cnt = st.wdog_cnt - 2'h1;
		next_st.wdog_run = !(STOP_MODE && st.clock_select[CLKS_WDOG_STOP_DIS_BIT]) && (next_st.wdog_cnt == 2'h0);
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CORE_CLK or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			st <= '0;
			st.synth <= SYNTH_RESET;
			st.reference_divider <= REFERENCE_DIVIDER_RESET;
			st.output_divider <= OUTPUT_DIVIDER_RESET;
			st.irq_enable <= IRQ_ENABLE_RESET;
			st.clock_select <= CLOCK_SELECT_RESET;
			st.osc_one <= OSC_ONE_RESET;
			st.osc_two <= OSC_TWO_RESET;
			st.protect <= PROTECT_RESET;
			st.wdog_run <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RDATA = st.rdata;
	assign REF_TICK = st.ref_tick;
	assign FB_TICK = st.fb_tick;
	assign PUMP_UP = st.pump_up;
	assign PUMP_DOWN = st.pump_down;
	assign PLL_TICK = st.pll_tick;
	assign BUS_TICK = st.bus_tick;
	assign BUS_FROM_PLL = st.clock_select[CLKS_BUS_PLL_BIT];
	assign EXT_OSC_ENABLE = st.osc_one[OSC1_ENABLE_BIT];
	// monitor reset only armed while the crystal runs
	assign OSC_MONITOR_RESET_EN = st.osc_two[OSC2_MONITOR_BIT] && st.osc_one[OSC1_ENABLE_BIT];
	assign OSC_FULL_SWING = st.osc_two[OSC2_SWING_BIT];
	assign REF_RANGE = st.reference_divider[RANGE_HI:RANGE_LO];
	assign VCO_RANGE = st.synth[RANGE_HI:RANGE_LO];
	assign LOCK = st.lock;
	assign LOCK_IRQ = st.lock_flag && st.irq_enable[IRQ_LOCK_BIT];
	assign REF_LOST = st.ref_lost;
	assign WATCHDOG_RUN = st.wdog_run;

endmodule

// ===== include/pll_clock_pkg.sv
// register map, field positions, reset values and timing counts of the clock generator
package pll_clock_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_SYNTH = 8'h10;
	localparam logic [7:0] ADDR_REFERENCE_DIVIDER = 8'h11;
	localparam logic [7:0] ADDR_OUTPUT_DIVIDER = 8'h12;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h13;
	localparam logic [7:0] ADDR_IRQ_FLAG = 8'h14;
	localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h19;
	localparam logic [7:0] ADDR_OSC_ONE = 8'h1A;
	localparam logic [7:0] ADDR_PROTECT = 8'h1B;
	localparam logic [7:0] ADDR_OSC_TWO = 8'h1E;
	// ****************************************
	// field positions
	// ****************************************
	localparam int OSC2_MONITOR_BIT = 1;
	localparam int OSC2_SWING_BIT = 0;
	localparam int OSC1_ENABLE_BIT = 7;
	localparam int CLKS_BUS_PLL_BIT = 7;
	localparam int CLKS_WDOG_STOP_DIS_BIT = 2;
	localparam int CLKS_WDOG_RC_BIT = 1;
	localparam int IRQ_LOCK_BIT = 4;
	localparam int STATUS_LOCK_BIT = 3;
	localparam int RANGE_HI = 7;
	localparam int RANGE_LO = 6;
	// ****************************************
	// reset values and keys
	// ****************************************
	localparam logic [7:0] SYNTH_RESET = 8'h58;
	localparam logic [7:0] REFERENCE_DIVIDER_RESET = 8'h00;
	localparam logic [7:0] OUTPUT_DIVIDER_RESET = 8'h03;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80;
	localparam logic [7:0] OSC_ONE_RESET = 8'h00;
	localparam logic [7:0] OSC_TWO_RESET = 8'h00;
	localparam logic PROTECT_RESET = 1'b0;
	localparam logic [7:0] PROTECT_UNLOCK_KEY = 8'h26;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int REF_TIMEOUT_NS = 20000;
	localparam int REF_TIMEOUT_CYCLES = REF_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [4:0] UNLOCKED_POST_DIV = 5'h03;
	localparam int LOCK_WINDOW = 8;
	localparam int LOCK_TOL = 1;
	localparam int UNLOCK_TOL = 3;
	localparam logic [1:0] WDOG_SYNC_CYCLES = 2'h3;
endpackage

// ===== test/pll_clock_sva.sv
// port assertions of the clock generator
`timescale 1ns/1ps
module pll_clock_sva
	import pll_clock_pkg::*;
#(
	parameter int REF_TIMEOUT = REF_TIMEOUT_CYCLES
)
(
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic IRC_TICK,
	input wire logic VCO_TICK,
	input wire logic REF_TICK,
	input wire logic FB_TICK,
	input wire logic PUMP_UP,
	input wire logic PUMP_DOWN,
	input wire logic PLL_TICK,
	input wire logic BUS_TICK,
	input wire logic BUS_FROM_PLL,
	input wire logic EXT_OSC_ENABLE,
	input wire logic OSC_MONITOR_RESET_EN,
	input wire logic OSC_FULL_SWING,
	input wire logic LOCK,
	input wire logic REF_LOST
);
	// ****************************************
	// helpers
	// ****************************************
	// live waits out the two-flop release of the internal reset
	logic [1:0] live;
	logic [7:0] gap;
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			live <= 2'h0;
			gap <= 8'h00;
		end
		else
		begin
			live <= {live[0], 1'b1};
			gap <= REF_TICK ? 8'h00 : gap + {7'h00, gap != 8'hFF};
		end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N || !live[1]);
	sequence s_ref_gone;
		$rose(REF_LOST);
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_ref_from_rc: assert property (!EXT_OSC_ENABLE && IRC_TICK |=> REF_TICK) else $error("reference tick missing");
	a_fb_from_vco: assert property (FB_TICK |-> $past(VCO_TICK)) else $error("feedback tick without oscillator tick");
	a_pll_from_vco: assert property (PLL_TICK |-> $past(VCO_TICK)) else $error("output tick without oscillator tick");
	a_bus_half: assert property (BUS_TICK && BUS_FROM_PLL |-> $past(PLL_TICK)) else $error("bus tick without output tick");
	a_pump_excl: assert property (!(PUMP_UP && PUMP_DOWN)) else $error("both pump directions at once");
	a_lost_unlock: assert property (s_ref_gone |-> ##[0:4] !LOCK) else $error("lock kept after reference loss");
	a_lost_late: assert property (s_ref_gone |-> gap >= REF_TIMEOUT - 2) else $error("reference loss flagged early");
	a_swing_frozen: assert property ($past(EXT_OSC_ENABLE) |-> $stable(OSC_FULL_SWING)) else $error("swing changed");
	a_monitor_gate: assert property (OSC_MONITOR_RESET_EN |-> EXT_OSC_ENABLE) else $error("monitor reset ungated");
	a_swing_cause: assert property ($changed(OSC_FULL_SWING) |-> $past(WR) && $past(ADDR) == ADDR_OSC_TWO
		&& $past(BUS_FROM_PLL) && !$past(EXT_OSC_ENABLE)) else $error("swing changed without legal write");
	a_read_window: assert property (RDATA != 8'h00 |-> $past(RD)) else $error("read data outside its cycle");
endmodule
bind pll_clock_generator pll_clock_sva #(.REF_TIMEOUT(REF_TIMEOUT)) u_sva (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .IRC_TICK(IRC_TICK), .VCO_TICK(VCO_TICK), .REF_TICK(REF_TICK),
	.FB_TICK(FB_TICK), .PUMP_UP(PUMP_UP), .PUMP_DOWN(PUMP_DOWN), .PLL_TICK(PLL_TICK), .BUS_TICK(BUS_TICK),
	.BUS_FROM_PLL(BUS_FROM_PLL), .EXT_OSC_ENABLE(EXT_OSC_ENABLE), .OSC_MONITOR_RESET_EN(OSC_MONITOR_RESET_EN),
	.OSC_FULL_SWING(OSC_FULL_SWING), .LOCK(LOCK), .REF_LOST(REF_LOST));

// ===== test/pll_clock_generator_tb.sv
// self-checking bench of the clock generator
`timescale 1ns/1ps
module pll_clock_generator_tb;
	import pll_clock_pkg::*;
	logic core_clk = 0, rst_n = 0, wr = 0, rd = 0, irc = 0, osc = 0, vco = 0, stop = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rnd;
	logic rd_seen = 0, ticks_on = 0;
	logic irq, wdog, pin_go = 0;
	logic [1:0] ref_rng, vco_rng;
	logic [7:0] pins;
	logic [7:0] pin_q[$];
	logic [7:0] exp_q[$];
	int miscompares = 0, tests_run = 0, cyc = 0;
	pll_clock_generator #(.REF_TIMEOUT(20)) DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .IRC_TICK(irc), .OSC_TICK(osc), .VCO_TICK(vco), .STOP_MODE(stop),
		.REF_TICK(), .FB_TICK(), .PUMP_UP(), .PUMP_DOWN(), .PLL_TICK(), .BUS_TICK(), .BUS_FROM_PLL(),
		.EXT_OSC_ENABLE(), .OSC_MONITOR_RESET_EN(), .OSC_FULL_SWING(), .REF_RANGE(ref_rng), .VCO_RANGE(vco_rng),
		.LOCK(), .LOCK_IRQ(irq), .REF_LOST(), .WATCHDOG_RUN(wdog));
	// pin vector: interrupt, watchdog run, reference range, oscillator range
	assign pins = {2'h0, irq, wdog, ref_rng, vco_rng};
	always #50 core_clk = ~core_clk;
	// ****************************************
	// tick sources and read monitor
	// ****************************************
	// two feedback edges per reference edge with multiplier 1
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		irc <= ticks_on && (cyc % 8 == 0);
		vco <= ticks_on && cyc[0];
		osc <= ticks_on && (cyc % 3 == 0);
	end
	always @(posedge core_clk)
	begin
		if (rd_seen)
			check(rdata, exp_q.pop_front());
		if (pin_go)
			check(pins, pin_q.pop_front());
		rd_seen <= rd;
	end
	// ****************************************
	// tasks
	// ****************************************
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task read_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(exp);
		@(posedge core_clk);
		rd <= 1'b0;
	endtask
	// two samples of the pin vector in a row, each taken the cycle after the request
	task expect_pins(input logic [7:0] e0, input logic [7:0] e1);
		@(posedge core_clk);
		pin_go <= 1'b1;
		pin_q.push_back(e0);
		@(posedge core_clk);
		pin_q.push_back(e1);
		@(posedge core_clk);
		pin_go <= 1'b0;
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		test_done;
	end
	initial
	begin
		rnd = 8'($urandom(92464));
		rnd = 8'($urandom());
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		read_reg(ADDR_SYNTH, SYNTH_RESET);
		read_reg(ADDR_OUTPUT_DIVIDER, OUTPUT_DIVIDER_RESET);
		read_reg(ADDR_CLOCK_SELECT, CLOCK_SELECT_RESET);
		read_reg(ADDR_OSC_TWO, OSC_TWO_RESET);
		write_reg(8'h3F, 8'hFF);
		read_reg(8'h3F, 8'h00);
		expect_pins(8'h11, 8'h11);
		$display("reset values done");
		write_reg(ADDR_PROTECT, 8'h00);
		write_reg(ADDR_OSC_TWO, 8'h03);
		read_reg(ADDR_OSC_TWO, 8'h00);
		write_reg(ADDR_PROTECT, PROTECT_UNLOCK_KEY);
		write_reg(ADDR_OSC_TWO, rnd | 8'h03);
		read_reg(ADDR_OSC_TWO, 8'h03);
		write_reg(ADDR_CLOCK_SELECT, 8'h00);
		write_reg(ADDR_OSC_TWO, 8'h00);
		read_reg(ADDR_OSC_TWO, 8'h03);
		write_reg(ADDR_CLOCK_SELECT, 8'h80);
		$display("protection done");
		write_reg(ADDR_SYNTH, 8'h41);
		write_reg(ADDR_OUTPUT_DIVIDER, 8'h00);
		write_reg(ADDR_IRQ_ENABLE, 8'h10);
		read_reg(ADDR_IRQ_ENABLE, 8'h10);
		ticks_on <= 1'b1;
		repeat (300) @(posedge core_clk);
		read_reg(ADDR_IRQ_FLAG, 8'h18);
		expect_pins(8'h31, 8'h31);
		write_reg(ADDR_IRQ_FLAG, 8'h18);
		read_reg(ADDR_IRQ_FLAG, 8'h08);
		expect_pins(8'h11, 8'h11);
		ticks_on <= 1'b0;
		repeat (60) @(posedge core_clk);
		read_reg(ADDR_IRQ_FLAG, 8'h10);
		expect_pins(8'h31, 8'h31);
		$display("lock done");
		write_reg(ADDR_OSC_ONE, 8'h80);
		write_reg(ADDR_OSC_TWO, ~rnd & 8'hFC);
		read_reg(ADDR_OSC_TWO, 8'h03);
		read_reg(ADDR_OSC_ONE, 8'h80);
		$display("oscillator freeze done");
		write_reg(ADDR_IRQ_ENABLE, 8'h00);
		write_reg(ADDR_CLOCK_SELECT, 8'h86);
		stop <= 1'b1;
		expect_pins(8'h01, 8'h01);
		stop <= 1'b0;
		repeat (2) @(posedge core_clk);
		// three extra held-off cycles after stop ends, then the watchdog runs
		expect_pins(8'h01, 8'h11);
		repeat (2) @(posedge core_clk);
		$display("watchdog restart done");
		test_done;
	end
endmodule
